// >>> hdl/ccp_timer_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CCP_TIMER_REGS_SVH
`define CCP_TIMER_REGS_SVH
`define OFF_FLAGS 8'h0c
`define OFF_FLAGS2 8'h0d
`define OFF_CNT_LOW 8'h0e
`define OFF_CNT_HIGH 8'h0f
`define OFF_TIMER_CTRL 8'h10
`define OFF_U1_LOW 8'h15
`define OFF_U1_HIGH 8'h16
`define OFF_U1_CTRL 8'h17
`define OFF_U2_LOW 8'h1b
`define OFF_U2_HIGH 8'h1c
`define OFF_U2_CTRL 8'h1d
`define OFF_ENABLES 8'h8c
`define OFF_ENABLES2 8'h8d
`define RST_TIMER_CTRL 8'h00
`define RST_UNIT_CTRL 8'h00
`define RST_FLAGS 8'h00
`define RST_ENABLES 8'h00
`define BIT_OVF_FLAG 0
`define BIT_U1_FLAG 2
`define BIT_U2_FLAG 0
`define FLAGS_MASK 8'h05
`define FLAGS2_MASK 8'h01
`define CTRL_MASK 8'h3f
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_4 4'h6
`define MODE_CAP_16 4'h7
`define MODE_CMP_HIGH 4'h8
`define MODE_CMP_LOW 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_TRIG 4'hb
`define CLK_PERIOD_NS 10
`define INSTR_PERIOD_NS 40
`define INSTR_DIV (`INSTR_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// >>> hdl/ccp_timer_pkg.sv
// types shared by the timer and capture/compare units
`default_nettype none
package ccp_timer_pkg;
`include "ccp_timer_regs.svh"
    typedef enum logic [3:0] {
        OP_OFF, OP_CAP_FALL, OP_CAP_RISE, OP_CAP_4, OP_CAP_16,
        OP_CMP_HIGH, OP_CMP_LOW, OP_CMP_SOFT, OP_CMP_TRIG, OP_PWM
    } unit_op_t;
    typedef struct packed {
        logic [1:0] unused;
        logic dutyLsbUpper;
        logic dutyLsbLower;
        logic [3:0] unitModeField;
    } unit_ctrl_t;
    typedef struct packed {
        logic [1:0] unused;
        logic prescaleSelectHigh;
        logic prescaleSelectLow;
        logic oscillatorEnable;
        logic externalClockSyncSelect;
        logic countSourceSelect;
        logic timerRunEnable;
    } timer_ctrl_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // reserved codes 0001..0011 fall back to off
    function automatic unit_op_t decode_mode(input logic [3:0] m);
        unit_op_t op;
        op = OP_OFF;
        if (m[3:2] == 2'h3) begin
            op = OP_PWM;
        end else begin
            case (m)
                `MODE_CAP_FALL: op = OP_CAP_FALL;
                `MODE_CAP_RISE: op = OP_CAP_RISE;
                `MODE_CAP_4: op = OP_CAP_4;
                `MODE_CAP_16: op = OP_CAP_16;
                `MODE_CMP_HIGH: op = OP_CMP_HIGH;
                `MODE_CMP_LOW: op = OP_CMP_LOW;
                `MODE_CMP_SOFT: op = OP_CMP_SOFT;
                `MODE_CMP_TRIG: op = OP_CMP_TRIG;
                default: op = OP_OFF;
            endcase
        end
        return op;
    endfunction
    function automatic logic is_compare(input unit_op_t op);
        return op inside {OP_CMP_HIGH, OP_CMP_LOW, OP_CMP_SOFT, OP_CMP_TRIG};
    endfunction
endpackage
`default_nettype wire

// >>> hdl/bit_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_r <= '0;
            syncOut <= '0;
        end else begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/ccp_unit.sv
// one capture/compare/PWM unit with its value register pair
`timescale 1ns/1ps
`default_nettype none
module ccp_unit (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic softRst,
    input var ccp_timer_pkg::unit_ctrl_t ctrl,
    input wire logic pinSync,
    input wire logic cycleTick,
    input wire logic timerTick,
    input wire logic [15:0] timerCnt,
    input wire logic [15:0] timerNext,
    input wire logic wrLow,
    input wire logic wrHigh,
    input wire logic [7:0] wdata,
    output logic [15:0] unitValue,
    output logic unitEvent,
    output logic specialTrig,
    output logic pinOut,
    output logic pinOe
);
    import ccp_timer_pkg::*;
    unit_op_t op, opPrev_r;
    logic pinPrev_r, rise, fall, matchNow, entering, capEv, cmpEv, oeNxt, pinNxt;
    logic [3:0] edgeCnt_r, edgeCnt_nxt;
    logic [9:0] pwmCnt_r, pwmCnt_nxt, duty;
    logic [15:0] value_nxt;

    assign op = decode_mode(ctrl.unitModeField);
    assign duty = {unitValue[7:0], ctrl.dutyLsbUpper, ctrl.dutyLsbLower};

    always_comb begin
        rise = pinSync & ~pinPrev_r;
        fall = ~pinSync & pinPrev_r;
        matchNow = timerTick && (timerNext == unitValue);
        entering = (op != opPrev_r);
        capEv = ((op == OP_CAP_FALL) && fall) || ((op == OP_CAP_RISE) && rise)
            || ((op == OP_CAP_4) && rise && (edgeCnt_r[1:0] == 2'h3))
            || ((op == OP_CAP_16) && rise && (edgeCnt_r == 4'hf));
        cmpEv = matchNow && is_compare(op);
        specialTrig = matchNow && (op == OP_CMP_TRIG);
        unitEvent = capEv | cmpEv;
        edgeCnt_nxt = edgeCnt_r;
        if (entering || softRst || !(op inside {OP_CAP_4, OP_CAP_16})) begin
            edgeCnt_nxt = 4'h0;
        end else if (rise) begin
            edgeCnt_nxt = edgeCnt_r + 4'h1;
        end
        value_nxt = unitValue;
        if (wrLow) begin
            value_nxt[7:0] = wdata;
        end
        if (wrHigh) begin
            value_nxt[15:8] = wdata;
        end
        // a capture beats a same-cycle software write; old results are lost
        if (capEv) begin
            value_nxt = timerCnt;
        end
        pwmCnt_nxt = (op == OP_PWM) ? pwmCnt_r + 10'(cycleTick) : 10'h000;
        pinNxt = 1'b0;
        if (op == OP_CMP_HIGH) begin
            pinNxt = entering ? 1'b0 : (matchNow ? 1'b1 : pinOut);
        end else if (op == OP_CMP_LOW) begin
            pinNxt = entering ? 1'b1 : (matchNow ? 1'b0 : pinOut);
        end else if (op == OP_PWM) begin
            pinNxt = pwmCnt_r < duty;
        end
        // soft interrupt and trigger modes leave the pin undriven
        oeNxt = op inside {OP_CMP_HIGH, OP_CMP_LOW, OP_PWM};
        if (softRst || op == OP_OFF) begin
            pinNxt = 1'b0;
            oeNxt = 1'b0;
            pwmCnt_nxt = 10'h000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opPrev_r <= OP_OFF;
            pinPrev_r <= 1'b0;
            edgeCnt_r <= 4'h0;
            pwmCnt_r <= 10'h000;
            unitValue <= 16'h0000;
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            opPrev_r <= softRst ? OP_OFF : op;
            pinPrev_r <= pinSync;
            edgeCnt_r <= edgeCnt_nxt;
            pwmCnt_r <= pwmCnt_nxt;
            unitValue <= value_nxt;
            pinOut <= pinNxt;
            pinOe <= oeNxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    capture_value_a: assert property (capEv |=> unitValue == $past(timerCnt))
        else $error("capture did not load timer count");
    every_fourth_a: assert property (capEv && op == OP_CAP_4 |-> edgeCnt_r[1:0] == 2'h3)
        else $error("divide-by-four capture on wrong edge");
    soft_pin_a: assert property (op == OP_CMP_SOFT && matchNow |-> unitEvent ##1 !pinOe)
        else $error("soft compare touched pin or missed flag");
    unit_off_a: assert property (op == OP_OFF |=> !pinOe && !pinOut && edgeCnt_r == 4'h0)
        else $error("off unit not cleared");
    pwm_level_a: assert property (op == OP_PWM && !entering && !softRst
        |=> pinOut == ($past(pwmCnt_r) < $past(duty)))
        else $error("pwm level wrong");
endmodule
`default_nettype wire

// >>> hdl/ccp_timer_top.sv
// shared 16-bit timer, its prescaler, two capture/compare units and registers
`timescale 1ns/1ps
`default_nettype none
`include "ccp_timer_regs.svh"
module ccp_timer_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic otherRst,
    input var ccp_timer_pkg::reg_req_t busReq,
    output logic [7:0] rdata,
    input wire logic extClkPin,
    input wire logic [1:0] unitPinIn,
    output logic [1:0] unitPinOut,
    output logic [1:0] unitPinOe,
    output logic irq
);
    import ccp_timer_pkg::*;

    localparam logic [7:0] LowOff [2] = '{`OFF_U1_LOW, `OFF_U2_LOW};
    localparam logic [7:0] HighOff [2] = '{`OFF_U1_HIGH, `OFF_U2_HIGH};
    localparam logic [7:0] CtrlOff [2] = '{`OFF_U1_CTRL, `OFF_U2_CTRL};

    function automatic logic wr_at(input reg_req_t r, input logic [7:0] off);
        return r.wr && (r.addr == off);
    endfunction

    // synchronised pins
    logic [2:0] pinsSync;
    logic extSync;
    logic [1:0] unitSync;

    bit_sync #(.WIDTH(3)) pinSyncI (
        .clk(clk),
        .arst_n(arst_n),
        .asyncIn({extClkPin, unitPinIn}),
        .syncOut(pinsSync)
    );
    assign extSync = pinsSync[2];
    assign unitSync = pinsSync[1:0];

    // instruction cycle divider and count source
    logic [1:0] divCnt_r, divCnt_nxt;
    logic cycleTick;
    logic extPrev_r, extPrev_nxt, extRise, srcTick;

    always_comb begin
        cycleTick = (divCnt_r == 2'(`INSTR_DIV - 1));
        divCnt_nxt = cycleTick ? 2'h0 : divCnt_r + 2'h1;
        extPrev_nxt = extSync;
        extRise = extSync & ~extPrev_r;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divCnt_r <= 2'h0;
            extPrev_r <= 1'b0;
        end else begin
            divCnt_r <= divCnt_nxt;
            extPrev_r <= extPrev_nxt;
        end
    end

    // timer control, only power-on reset clears it
    timer_ctrl_t tctrl_r, tctrl_nxt;
    logic tctrlWr;

    always_comb begin
        tctrlWr = wr_at(busReq, `OFF_TIMER_CTRL);
        tctrl_nxt = tctrl_r;
        if (tctrlWr) begin
            tctrl_nxt = timer_ctrl_t'(busReq.wdata & `CTRL_MASK);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tctrl_r <= timer_ctrl_t'(`RST_TIMER_CTRL);
        end else begin
            tctrl_r <= tctrl_nxt;
        end
    end

    // the pin edge is always resynchronised, so the sync select bit is
    // only stored; asynchronous counting is not offered
    assign srcTick = tctrl_r.countSourceSelect ? extRise : cycleTick;

    // prescaler
    logic [2:0] pre_r, pre_nxt, preLimit;
    logic cntWrLow, cntWrHigh, cntWr, timerTick;

    always_comb begin
        cntWrLow = wr_at(busReq, `OFF_CNT_LOW);
        cntWrHigh = wr_at(busReq, `OFF_CNT_HIGH);
        cntWr = cntWrLow | cntWrHigh;
        preLimit = 3'((3'h1 << {tctrl_r.prescaleSelectHigh, tctrl_r.prescaleSelectLow}) - 3'h1);
        timerTick = tctrl_r.timerRunEnable && srcTick && (pre_r == preLimit);
        pre_nxt = pre_r;
        if (cntWr) begin
            pre_nxt = 3'h0;
        end else if (tctrl_r.timerRunEnable && srcTick) begin
            pre_nxt = timerTick ? 3'h0 : pre_r + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_r <= 3'h0;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    // timer count
    logic [15:0] cnt_r, cnt_nxt, cntNext;
    logic [1:0] trigs;
    logic trig, ovfEv;

    assign trig = |trigs;

    always_comb begin
        cntNext = cnt_r + 16'h0001;
        cnt_nxt = cnt_r;
        ovfEv = 1'b0;
        // a software write beats a same-cycle trigger
        if (cntWrLow || cntWrHigh) begin
            if (cntWrLow) begin
                cnt_nxt[7:0] = busReq.wdata;
            end
            if (cntWrHigh) begin
                cnt_nxt[15:8] = busReq.wdata;
            end
        end else if (trig) begin
            cnt_nxt = 16'h0000;
        end else if (timerTick) begin
            cnt_nxt = cntNext;
            ovfEv = (cnt_r == 16'hffff);
        end
    end

    // count bytes carry no reset at all, not even the soft one
    always_ff @(posedge clk) begin
        cnt_r <= cnt_nxt;
    end

    // unit control registers and units
    unit_ctrl_t uctrl_r [2];
    unit_ctrl_t uctrl_nxt [2];
    logic [15:0] unitValue [2];
    logic [1:0] unitEvent;

    for (genvar u = 0; u < 2; u++) begin : gUnit
        always_comb begin
            uctrl_nxt[u] = uctrl_r[u];
            if (otherRst) begin
                uctrl_nxt[u] = unit_ctrl_t'(`RST_UNIT_CTRL);
            end else if (wr_at(busReq, CtrlOff[u])) begin
                uctrl_nxt[u] = unit_ctrl_t'(busReq.wdata & `CTRL_MASK);
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                uctrl_r[u] <= unit_ctrl_t'(`RST_UNIT_CTRL);
            end else begin
                uctrl_r[u] <= uctrl_nxt[u];
            end
        end

        ccp_unit unitI (
            .clk(clk),
            .arst_n(arst_n),
            .softRst(otherRst),
            .ctrl(uctrl_r[u]),
            .pinSync(unitSync[u]),
            .cycleTick(cycleTick),
            .timerTick(timerTick),
            .timerCnt(cnt_r),
            .timerNext(cntNext),
            .wrLow(wr_at(busReq, LowOff[u])),
            .wrHigh(wr_at(busReq, HighOff[u])),
            .wdata(busReq.wdata),
            .unitValue(unitValue[u]),
            .unitEvent(unitEvent[u]),
            .specialTrig(trigs[u]),
            .pinOut(unitPinOut[u]),
            .pinOe(unitPinOe[u])
        );
    end

    // interrupt flags, enables and read port
    logic [7:0] flags_r, flags_nxt, flags2_r, flags2_nxt;
    logic [7:0] en_r, en_nxt, en2_r, en2_nxt, rdata_nxt;

    always_comb begin
        flags_nxt = flags_r;
        flags2_nxt = flags2_r;
        en_nxt = en_r;
        en2_nxt = en2_r;
        if (otherRst) begin
            flags_nxt = `RST_FLAGS;
            flags2_nxt = `RST_FLAGS;
            en_nxt = `RST_ENABLES;
            en2_nxt = `RST_ENABLES;
        end else begin
            if (wr_at(busReq, `OFF_FLAGS)) begin
                flags_nxt = flags_r & ~busReq.wdata;
            end
            if (wr_at(busReq, `OFF_FLAGS2)) begin
                flags2_nxt = flags2_r & ~busReq.wdata;
            end
            if (wr_at(busReq, `OFF_ENABLES)) begin
                en_nxt = busReq.wdata & `FLAGS_MASK;
            end
            if (wr_at(busReq, `OFF_ENABLES2)) begin
                en2_nxt = busReq.wdata & `FLAGS2_MASK;
            end
        end
        // set after clear, so an event in the clearing cycle is kept
        flags_nxt[`BIT_OVF_FLAG] = flags_nxt[`BIT_OVF_FLAG] | ovfEv;
        flags_nxt[`BIT_U1_FLAG] = flags_nxt[`BIT_U1_FLAG] | unitEvent[0];
        flags2_nxt[`BIT_U2_FLAG] = flags2_nxt[`BIT_U2_FLAG] | unitEvent[1];
        rdata_nxt = 8'h00;
        if (busReq.rd) begin
            case (busReq.addr)
                `OFF_FLAGS: rdata_nxt = flags_r;
                `OFF_FLAGS2: rdata_nxt = flags2_r;
                `OFF_CNT_LOW: rdata_nxt = cnt_r[7:0];
                `OFF_CNT_HIGH: rdata_nxt = cnt_r[15:8];
                `OFF_TIMER_CTRL: rdata_nxt = tctrl_r;
                `OFF_U1_LOW: rdata_nxt = unitValue[0][7:0];
                `OFF_U1_HIGH: rdata_nxt = unitValue[0][15:8];
                `OFF_U1_CTRL: rdata_nxt = uctrl_r[0];
                `OFF_U2_LOW: rdata_nxt = unitValue[1][7:0];
                `OFF_U2_HIGH: rdata_nxt = unitValue[1][15:8];
                `OFF_U2_CTRL: rdata_nxt = uctrl_r[1];
                `OFF_ENABLES: rdata_nxt = en_r;
                `OFF_ENABLES2: rdata_nxt = en2_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_r <= `RST_FLAGS;
            flags2_r <= `RST_FLAGS;
            en_r <= `RST_ENABLES;
            en2_r <= `RST_ENABLES;
            rdata <= 8'h00;
        end else begin
            flags_r <= flags_nxt;
            flags2_r <= flags2_nxt;
            en_r <= en_nxt;
            en2_r <= en2_nxt;
            rdata <= rdata_nxt;
        end
    end

    assign irq = |(flags_r & en_r) | |(flags2_r & en2_r);

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence trigNoWrite;
        trig && !cntWr;
    endsequence
    sequence countAtZero;
        cnt_r == 16'h0000;
    endsequence

    trig_reset_a: assert property (trigNoWrite |=> countAtZero)
        else $error("trigger did not zero the timer");
    no_ovf_trig_a: assert property (trig |-> !ovfEv)
        else $error("trigger raised overflow");
    write_wins_a: assert property (cntWrLow && trig |=> cnt_r[7:0] == $past(busReq.wdata))
        else $error("trigger beat a timer write");
    period_match_a: assert property (trigs[0] |-> timerTick && cntNext == unitValue[0])
        else $error("trigger without period match");
    count_kept_a: assert property (otherRst && !timerTick && !cntWr && !trig
        |=> $stable(cnt_r))
        else $error("soft reset disturbed timer count");
    ctrl_kept_a: assert property (otherRst && !tctrlWr |=> $stable(tctrl_r))
        else $error("soft reset changed timer control");
    pre_clear_a: assert property (cntWr |=> pre_r == 3'h0)
        else $error("count write left prescaler running");
    flag_sticky_a: assert property (flags_r[`BIT_U1_FLAG] && !otherRst
        && !(wr_at(busReq, `OFF_FLAGS) && busReq.wdata[`BIT_U1_FLAG])
        |=> flags_r[`BIT_U1_FLAG])
        else $error("unit flag dropped without clear");
    flag_set_a: assert property (unitEvent[0] |=> flags_r[`BIT_U1_FLAG])
        else $error("unit event lost");
endmodule
`default_nettype wire

// >>> verif/test_ccp_timer_top.sv
// register-level testbench for the timer with its two capture/compare units
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) chk(n, 16'(e), 16'(g))
module test_ccp_timer_top;
    import ccp_timer_pkg::*;
    logic clk, arst_n, otherRst;
    reg_req_t busReq;
    logic [7:0] rdata, v, lo;
    logic [1:0] unitPinIn, unitPinOut, unitPinOe;
    logic irq, irqSeen, anyHigh, extClk;
    int mismatches, cmp_count;
    ccp_timer_top dut (.clk(clk), .arst_n(arst_n), .otherRst(otherRst), .busReq(busReq),
        .rdata(rdata), .extClkPin(extClk), .unitPinIn(unitPinIn), .unitPinOut(unitPinOut),
        .unitPinOe(unitPinOe), .irq(irq));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // strobe is dropped for a cycle so back-to-back calls never double-assign it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        // read data stand only in the cycle after the strobe
        #1;
        d = rdata;
        irqSeen = irq;
        @(posedge clk);
    endtask
    task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] e);
        rd(a, v);
        `CHECK(n, e, v);
    endtask
    task automatic waitFlag(input logic [7:0] a, input int b);
        for (int i = 0; i < 300; i++) begin
            rd(a, v);
            if (v[b] === 1'b1) break;
        end
        `CHECK("flag wait", 1'b1, v[b]);
    endtask
    task automatic pulse(input int u);
        unitPinIn[u] <= 1'b1;
        cyc(6);
        unitPinIn[u] <= 1'b0;
        cyc(6);
    endtask
    task automatic setCount(input logic [15:0] c);
        wr(8'h0e, c[7:0]);
        wr(8'h0f, c[15:8]);
    endtask
    task automatic cap(input int u, input logic [3:0] m, input int n, input logic [15:0] c);
        logic [7:0] uo, fa;
        int fb;
        uo = u ? 8'h1b : 8'h15;
        fa = u ? 8'h0d : 8'h0c;
        fb = u ? 0 : 2;
        wr(8'h10, 8'h00);
        setCount(c);
        wr(uo + 8'h02, {4'h0, m});
        wr(fa, 8'h01 << fb);
        for (int i = 0; i < n; i++) begin
            if (i == n - 1) begin
                rd(fa, v);
                `CHECK("early capture", 1'b0, v[fb]);
            end
            pulse(u);
        end
        rd(fa, v);
        `CHECK("capture flag", 1'b1, v[fb]);
        rdChk("capture low", uo, c[7:0]);
        rdChk("capture high", uo + 8'h01, c[15:8]);
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        mismatches++;
        results;
    end
    initial begin
        arst_n = 0;
        otherRst = 0;
        busReq = '0;
        unitPinIn = 2'h0;
        extClk = 1'b0;
        cyc(10);
        arst_n <= 1'b1;
        @(posedge clk);
        rdChk("timer ctrl reset", 8'h10, 8'h00);
        rdChk("unit1 ctrl reset", 8'h17, 8'h00);
        rdChk("unit2 ctrl reset", 8'h1d, 8'h00);
        rdChk("flags reset", 8'h0c, 8'h00);
        rdChk("enables reset", 8'h8c, 8'h00);
        wr(8'h1e, 8'ha5);
        rdChk("unmapped", 8'h1e, 8'h00);
        wr(8'h17, 8'hff);
        rdChk("ctrl reserved bits", 8'h17, 8'h3f);
        wr(8'h17, 8'h00);
        done("reset values");
        // other reset keeps timer control and count; power-on reset keeps count only
        wr(8'h10, 8'h30);
        wr(8'h17, 8'h0b);
        setCount(16'ha55a);
        otherRst <= 1'b1;
        cyc(2);
        otherRst <= 1'b0;
        @(posedge clk);
        rdChk("ctrl after other reset", 8'h10, 8'h30);
        rdChk("unit after other reset", 8'h17, 8'h00);
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        @(posedge clk);
        rdChk("ctrl after por", 8'h10, 8'h00);
        rdChk("count low kept", 8'h0e, 8'h5a);
        rdChk("count high kept", 8'h0f, 8'ha5);
        done("resets");
        // overflow flag, interrupt enable and masking
        setCount(16'hfffe);
        wr(8'h8c, 8'h01);
        wr(8'h10, 8'h01);
        waitFlag(8'h0c, 0);
        `CHECK("irq enabled", 1'b1, irqSeen);
        wr(8'h8c, 8'h00);
        rd(8'h0c, v);
        `CHECK("irq masked", 1'b0, irqSeen);
        wr(8'h8c, 8'h01);
        wr(8'h0c, 8'h01);
        rdChk("flag cleared", 8'h0c, 8'h00);
        `CHECK("irq cleared", 1'b0, irqSeen);
        wr(8'h8c, 8'h00);
        done("interrupts");
        // prescaler cleared by each count write, so 1:8 never reaches a tick
        wr(8'h10, 8'h31);
        for (int i = 0; i < 4; i++) begin
            wr(8'h0e, 8'h00);
            cyc(14);
            rdChk("prescaler cleared", 8'h0e, 8'h00);
        end
        done("prescaler");
        // synchronized counter mode counts the resynchronised external edges
        wr(8'h10, 8'h00);
        setCount(16'h0000);
        wr(8'h10, 8'h03);
        repeat (5) begin
            extClk <= 1'b1;
            cyc(3);
            extClk <= 1'b0;
            cyc(3);
        end
        rdChk("external count", 8'h0e, 8'h05);
        done("counter");
        // trigger mode: period of 0x10, no overflow flag
        wr(8'h10, 8'h00);
        wr(8'h15, 8'h10);
        wr(8'h16, 8'h00);
        wr(8'h17, 8'h0b);
        setCount(16'h0000);
        wr(8'h0c, 8'h05);
        wr(8'h10, 8'h01);
        waitFlag(8'h0c, 2);
        // writes three cycles apart meet the trigger tick in every phase
        for (int i = 0; i < 8; i++) begin
            wr(8'h0e, 8'h0f);
            @(posedge clk);
        end
        cyc(300);
        rd(8'h0e, lo);
        `CHECK("wrapped below period", 1'b1, lo < 8'h10);
        rdChk("count high after wraps", 8'h0f, 8'h00);
        rd(8'h0c, v);
        `CHECK("no overflow flag", 1'b0, v[0]);
        done("trigger");
        // compare modes: soft leaves pin alone, high mode drives it
        wr(8'h15, 8'h08);
        wr(8'h17, 8'h0a);
        setCount(16'h0000);
        wr(8'h0c, 8'h04);
        waitFlag(8'h0c, 2);
        `CHECK("soft pin undriven", 1'b0, unitPinOe[0]);
        wr(8'h17, 8'h08);
        setCount(16'h0000);
        `CHECK("high mode start", 2'h2, {unitPinOe[0], unitPinOut[0]});
        wr(8'h0c, 8'h04);
        waitFlag(8'h0c, 2);
        `CHECK("high mode match", 2'h3, {unitPinOe[0], unitPinOut[0]});
        wr(8'h17, 8'h09);
        setCount(16'h0000);
        `CHECK("low mode start", 2'h3, {unitPinOe[0], unitPinOut[0]});
        wr(8'h0c, 8'h04);
        waitFlag(8'h0c, 2);
        `CHECK("low mode match", 2'h2, {unitPinOe[0], unitPinOut[0]});
        wr(8'h17, 8'h00);
        cyc(2);
        `CHECK("off releases pin", 1'b0, unitPinOe[0]);
        done("compare");
        // capture every event kind on unit one, two rising captures on unit two
        cap(0, 4'h4, 1, 16'h1234);
        cap(0, 4'h5, 1, 16'h2345);
        cap(0, 4'h6, 4, 16'h3456);
        cap(0, 4'h7, 16, 16'h4567);
        cap(1, 4'h5, 1, 16'hbeef);
        `CHECK("capture pin released", 2'h0, {unitPinOe[1], unitPinOut[1]});
        setCount(16'h9abc);
        pulse(1);
        rdChk("overwrite low", 8'h1b, 8'hbc);
        rdChk("overwrite high", 8'h1c, 8'h9a);
        rdChk("flag still set", 8'h0d, 8'h01);
        wr(8'h1d, 8'h00);
        wr(8'h17, 8'h00);
        done("capture");
        // pwm: duty zero keeps pin low, full duty shows high
        wr(8'h10, 8'h01);
        wr(8'h15, 8'h00);
        wr(8'h17, 8'h0c);
        rdChk("pwm ctrl", 8'h17, 8'h0c);
        anyHigh = 1'b0;
        repeat (40) begin
            @(posedge clk);
            anyHigh = anyHigh | (unitPinOut[0] === 1'b1);
        end
        `CHECK("pwm duty zero", 1'b0, anyHigh);
        `CHECK("pwm drives pin", 1'b1, unitPinOe[0]);
        wr(8'h15, 8'hff);
        wr(8'h17, 8'h3f);
        rdChk("duty lsbs stored", 8'h17, 8'h3f);
        repeat (40) begin
            @(posedge clk);
            anyHigh = anyHigh | (unitPinOut[0] === 1'b1);
        end
        `CHECK("pwm duty full", 1'b1, anyHigh);
        done("pwm");
        results;
    end
endmodule
`default_nettype wire
